// [nfcfg_pkg.sv]
// package for the flash configuration register block
// assumes a 32-bit avalon-mm slave with word addressing by byte offset
package nfcfg_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] NFCFG_BASE_ADDR = 32'h4E000000;
  localparam logic [7:0] NFCFG_CONF_OFS = 8'h00;
  localparam logic [7:0] NFCFG_SLEEP_OFS = 8'h04;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int NFCFG_MSG_BIT = 25;
  localparam int NFCFG_ECC_HI = 24;
  localparam int NFCFG_ECC_LO = 23;
  localparam int NFCFG_TACL_HI = 14;
  localparam int NFCFG_TACL_LO = 12;
  localparam int NFCFG_PHA_HI = 10;
  localparam int NFCFG_PHA_LO = 8;
  localparam int NFCFG_PHB_HI = 6;
  localparam int NFCFG_PHB_LO = 4;
  localparam int NFCFG_PAGE_BIT = 3;
  localparam int NFCFG_CLASS_BIT = 2;
  localparam int NFCFG_ADDR_BIT = 1;
  localparam int NFCFG_WIDTH_BIT = 0;
  localparam logic [31:0] NFCFG_WMASK = 32'h0380777F;
  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [2:0] NFCFG_TACL_RST = 3'h1;
  localparam logic [2:0] NFCFG_PH_RST = 3'h0;
  localparam logic NFCFG_MSG_RST = 1'b0;
  localparam logic NFCFG_CLASS_RST = 1'b1;
  localparam logic [1:0] NFCFG_ECC_1BIT = 2'h0;
  localparam logic [1:0] NFCFG_ECC_4BIT = 2'h2;
  localparam logic [1:0] NFCFG_ECC_8BIT = 2'h1;
  localparam logic [9:0] NFCFG_MSG_LONG = 10'h200;
  localparam logic [9:0] NFCFG_MSG_SHORT = 10'h018;
  localparam logic [12:0] NFCFG_PG_512 = 13'h0200;
  localparam logic [12:0] NFCFG_PG_2K = 13'h0800;
  localparam logic [12:0] NFCFG_PG_4K = 13'h1000;
  typedef enum logic [1:0] {
    nfcfg_ecc_one,
    nfcfg_ecc_four,
    nfcfg_ecc_eight,
    nfcfg_ecc_bad
  } nfcfg_ecc_e;
endpackage : nfcfg_pkg

// [nfcfg_decode.sv]
// decodes configuration fields into sizes and counts
// assumes purely combinational use by the register block
`timescale 1ns/1ps
module nfcfg_decode
  import nfcfg_pkg::*;
(
  input wire logic [1:0] ecc_kind_select,
  input wire logic ecc_message_length,
  input wire logic page_bytes_select,
  input wire logic flash_class_select,
  input wire logic address_cycle_count,
  output nfcfg_ecc_e ecc_kind,
  output logic [9:0] msg_bytes,
  output logic [12:0] page_bytes,
  output logic [2:0] addr_cycles
);
  always_comb begin
    case (ecc_kind_select)
      NFCFG_ECC_1BIT: ecc_kind = nfcfg_ecc_one;
      NFCFG_ECC_4BIT: ecc_kind = nfcfg_ecc_four;
      NFCFG_ECC_8BIT: ecc_kind = nfcfg_ecc_eight;
      default: ecc_kind = nfcfg_ecc_bad;
    endcase
    msg_bytes = ecc_message_length ? NFCFG_MSG_SHORT : NFCFG_MSG_LONG;
    if (flash_class_select) begin
      page_bytes = page_bytes_select ? NFCFG_PG_2K : NFCFG_PG_512;
    end else begin
      page_bytes = page_bytes_select ? NFCFG_PG_4K : NFCFG_PG_2K;
    end
    if (flash_class_select && !page_bytes_select) begin
      addr_cycles = address_cycle_count ? 3'h4 : 3'h3;
    end else begin
      addr_cycles = address_cycle_count ? 3'h5 : 3'h4;
    end
  end
endmodule : nfcfg_decode

// [nfcfg_timer.sv]
// counts strobe phases: latch setup, write pulse a, write pulse b
// assumes start is a one-cycle pulse while idle
`timescale 1ns/1ps
module nfcfg_timer
  import nfcfg_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic start,
  input wire logic [2:0] latch_strobe_duration,
  input wire logic [2:0] write_pulse_phase_a,
  input wire logic [2:0] write_pulse_phase_b,
  output logic latch_phase,
  output logic pulse_a_phase,
  output logic pulse_b_phase,
  output logic busy
);
  typedef enum {idle_st, latch_st, pa_st, pb_st} nfcfg_tim_e;
  nfcfg_tim_e st_r, st_nxt;
  logic [2:0] cnt_r, cnt_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      idle_st: begin
        if (start) begin
          if (latch_strobe_duration != 3'h0) begin
            st_nxt = latch_st;
            cnt_nxt = latch_strobe_duration - 3'h1;
          end else begin
            st_nxt = pa_st;
            cnt_nxt = write_pulse_phase_a;
          end
        end
      end
      latch_st: begin
        if (cnt_r == 3'h0) begin
          st_nxt = pa_st;
          cnt_nxt = write_pulse_phase_a;
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      pa_st: begin
        if (cnt_r == 3'h0) begin
          st_nxt = pb_st;
          cnt_nxt = write_pulse_phase_b;
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      pb_st: begin
        if (cnt_r == 3'h0) begin
          st_nxt = idle_st;
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      default: st_nxt = idle_st;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= idle_st;
      cnt_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign latch_phase = (st_r == latch_st);
  assign pulse_a_phase = (st_r == pa_st);
  assign pulse_b_phase = (st_r == pb_st);
  assign busy = (st_r != idle_st);
endmodule : nfcfg_timer

// [nfcfg_regs.sv]
// flash configuration register with avalon-mm slave and strobe timer
// assumes boot straps are stable around reset release and wake
`timescale 1ns/1ps
module nfcfg_regs
  import nfcfg_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic boot_mode_pin_two,
  input wire logic boot_mode_pin_one,
  input wire logic [1:0] boot_ecc_strap,
  input wire logic boot_page_strap,
  input wire logic boot_width_strap,
  input wire logic wake_from_sleep,
  input wire logic internal_boot_rom,
  input wire logic cycle_start,
  output logic [31:0] flash_configuration,
  output logic latch_strobe,
  output logic write_phase_a,
  output logic write_phase_b,
  output logic cycle_busy,
  output logic [2:0] addr_cycles_out,
  output logic [12:0] page_bytes_out,
  output logic [9:0] msg_bytes_out,
  output logic [1:0] ecc_kind_out,
  output logic wide_io
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] conf_r, conf_nxt;
  logic load_r, load_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic sleep_r, sleep_nxt;
  logic lat_r, lat_nxt;
  logic pha_r, pha_nxt;
  logic phb_r, phb_nxt;
  logic busy_r, busy_nxt;
  logic [2:0] acyc_r, acyc_nxt;
  logic [12:0] pg_r, pg_nxt;
  logic [9:0] msg_r, msg_nxt;
  logic [1:0] ecc_r, ecc_nxt;
  logic wide_r, wide_nxt;
  nfcfg_ecc_e ecc_kind;
  logic [9:0] msg_bytes;
  logic [12:0] page_bytes;
  logic [2:0] addr_cycles;
  logic t_lat, t_pa, t_pb, t_busy;
  logic [31:0] bmask;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // ----------------------------------------------------------------
  // decode and timing
  // ----------------------------------------------------------------
  nfcfg_decode u_dec (
    .ecc_kind_select(conf_r[NFCFG_ECC_HI:NFCFG_ECC_LO]),
    .ecc_message_length(conf_r[NFCFG_MSG_BIT]),
    .page_bytes_select(conf_r[NFCFG_PAGE_BIT]),
    .flash_class_select(conf_r[NFCFG_CLASS_BIT]),
    .address_cycle_count(conf_r[NFCFG_ADDR_BIT]),
    .ecc_kind(ecc_kind),
    .msg_bytes(msg_bytes),
    .page_bytes(page_bytes),
    .addr_cycles(addr_cycles)
  );

  nfcfg_timer u_tim (
    .clock(clock),
    .nrst(nrst),
    .start(cycle_start),
    .latch_strobe_duration(conf_r[NFCFG_TACL_HI:NFCFG_TACL_LO]),
    .write_pulse_phase_a(conf_r[NFCFG_PHA_HI:NFCFG_PHA_LO]),
    .write_pulse_phase_b(conf_r[NFCFG_PHB_HI:NFCFG_PHB_LO]),
    .latch_phase(t_lat),
    .pulse_a_phase(t_pa),
    .pulse_b_phase(t_pb),
    .busy(t_busy)
  );

  // ----------------------------------------------------------------
  // register and bus logic
  // ----------------------------------------------------------------
  always_comb begin
    conf_nxt = conf_r;
    load_nxt = 1'b0;
    ack_nxt = 1'b0;
    rd_nxt = rd_r;
    sleep_nxt = wake_from_sleep;
    bmask = lane_mask(avs_byteenable) & NFCFG_WMASK;
    // straps and mode pins load one cycle after reset release; only the two mode pins reload on wake rising edge
    if (load_r || (wake_from_sleep && !sleep_r)) begin
      conf_nxt[NFCFG_CLASS_BIT] = boot_mode_pin_two;
      conf_nxt[NFCFG_ADDR_BIT] = boot_mode_pin_one;
    end
    if (load_r) begin
      conf_nxt[NFCFG_ECC_HI:NFCFG_ECC_LO] = boot_ecc_strap;
      conf_nxt[NFCFG_PAGE_BIT] = boot_page_strap;
      conf_nxt[NFCFG_WIDTH_BIT] = boot_width_strap;
    end
    // one wait state per access: waitrequest drops in the second cycle
    if ((avs_read || avs_write) && !ack_r) begin
      ack_nxt = 1'b1;
      if (avs_address == NFCFG_CONF_OFS) begin
        if (avs_write) begin
          conf_nxt = (conf_r & ~bmask) | (avs_writedata & bmask);
        end
        rd_nxt = conf_r;
      end else if (avs_address == NFCFG_SLEEP_OFS) begin
        rd_nxt = {31'h00000000, sleep_r};
      end else begin
        rd_nxt = 32'h00000000;
      end
      if (avs_write) begin
        rd_nxt = 32'h00000000;
      end
    end
    lat_nxt = t_lat;
    pha_nxt = t_pa;
    phb_nxt = t_pb;
    busy_nxt = t_busy;
    acyc_nxt = addr_cycles;
    pg_nxt = page_bytes;
    msg_nxt = msg_bytes;
    ecc_nxt = ecc_kind;
    // rom boot always runs the 8-bit bus
    wide_nxt = conf_r[NFCFG_WIDTH_BIT] && !internal_boot_rom;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      conf_r <= {6'h00, NFCFG_MSG_RST, 2'h0, 8'h00, NFCFG_TACL_RST, 1'b0,
                 NFCFG_PH_RST, 1'b0, NFCFG_PH_RST, 1'b0, NFCFG_CLASS_RST,
                 2'h0};
      load_r <= 1'b1;
      ack_r <= 1'b0;
      rd_r <= 32'h00000000;
      sleep_r <= 1'b0;
      lat_r <= 1'b0;
      pha_r <= 1'b0;
      phb_r <= 1'b0;
      busy_r <= 1'b0;
      acyc_r <= 3'h0;
      pg_r <= 13'h0000;
      msg_r <= 10'h000;
      ecc_r <= 2'h0;
      wide_r <= 1'b0;
    end else begin
      conf_r <= conf_nxt;
      load_r <= load_nxt;
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
      sleep_r <= sleep_nxt;
      lat_r <= lat_nxt;
      pha_r <= pha_nxt;
      phb_r <= phb_nxt;
      busy_r <= busy_nxt;
      acyc_r <= acyc_nxt;
      pg_r <= pg_nxt;
      msg_r <= msg_nxt;
      ecc_r <= ecc_nxt;
      wide_r <= wide_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata = rd_r;
  assign avs_waitrequest = !ack_r;
  assign flash_configuration = conf_r;
  assign latch_strobe = lat_r;
  assign write_phase_a = pha_r;
  assign write_phase_b = phb_r;
  assign cycle_busy = busy_r;
  assign addr_cycles_out = acyc_r;
  assign page_bytes_out = pg_r;
  assign msg_bytes_out = msg_r;
  assign ecc_kind_out = ecc_r;
  assign wide_io = wide_r;
endmodule : nfcfg_regs

// [nfcfg_regs_asserts.sv]
// checker on the ports of the flash configuration register block
// assumes one clock domain and an async active-low reset
`timescale 1ns/1ps
module nfcfg_regs_asserts
  import nfcfg_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [31:0] flash_configuration,
  input wire logic latch_strobe,
  input wire logic write_phase_a,
  input wire logic write_phase_b,
  input wire logic wake_from_sleep,
  input wire logic boot_mode_pin_two,
  input wire logic boot_mode_pin_one,
  input wire logic [1:0] boot_ecc_strap,
  input wire logic boot_page_strap,
  input wire logic boot_width_strap,
  input wire logic internal_boot_rom,
  input wire logic wide_io,
  input wire logic [2:0] addr_cycles_out,
  input wire logic [12:0] page_bytes_out,
  input wire logic [9:0] msg_bytes_out,
  input wire logic [1:0] ecc_kind_out
);
  // ----------------------------------------------------------------
  // helpers: edges since release, previous word, strobe run lengths
  // ----------------------------------------------------------------
  logic [1:0] up_r;
  logic [31:0] c_r;
  logic [3:0] l_r, a_r, b_r;
  logic up;
  assign up = up_r == 2'h3;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      up_r <= 2'h0;
    end else if (!up) begin
      up_r <= up_r + 2'h1;
    end
  end
  always_ff @(posedge clock) begin
    c_r <= flash_configuration;
    l_r <= latch_strobe ? l_r + 4'h1 : 4'h0;
    a_r <= write_phase_a ? a_r + 4'h1 : 4'h0;
    b_r <= write_phase_b ? b_r + 4'h1 : 4'h0;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_msg;
    up |-> msg_bytes_out == (c_r[25] ? NFCFG_MSG_SHORT : NFCFG_MSG_LONG);
  endproperty
  a_msg: assert property (p_msg) else $error("msg length decode");
  property p_ecc; up |-> ecc_kind_out == {c_r[23], c_r[24]}; endproperty
  a_ecc: assert property (p_ecc) else $error("ecc kind decode");
  property p_page;
    up |-> page_bytes_out == (c_r[2] ? (c_r[3] ? NFCFG_PG_2K : NFCFG_PG_512)
      : (c_r[3] ? NFCFG_PG_4K : NFCFG_PG_2K));
  endproperty
  a_page: assert property (p_page) else $error("page decode");
  property p_addr;
    up |-> addr_cycles_out == (c_r[2] && !c_r[3] ? 3'h3 : 3'h4) + c_r[1];
  endproperty
  a_addr: assert property (p_addr) else $error("addr cycles");
  property p_lat;
    $fell(latch_strobe) |-> l_r == {1'b0, flash_configuration[14:12]};
  endproperty
  a_lat: assert property (p_lat) else $error("latch length");
  property p_pha;
    $fell(write_phase_a) |-> a_r == flash_configuration[10:8] + 4'h1;
  endproperty
  a_pha: assert property (p_pha) else $error("phase a length");
  property p_phb;
    $fell(write_phase_b) |-> b_r == flash_configuration[6:4] + 4'h1;
  endproperty
  a_phb: assert property (p_phb) else $error("phase b length");
  property p_wid;
    up && $stable(internal_boot_rom) |->
      wide_io == (c_r[0] && !internal_boot_rom);
  endproperty
  a_wid: assert property (p_wid) else $error("io width");
  property p_wake;
    $rose(wake_from_sleep) |-> ##[1:3]
      flash_configuration[2:1] == {boot_mode_pin_two, boot_mode_pin_one};
  endproperty
  a_wake: assert property (p_wake) else $error("wake reload");
  property p_strap;
    up_r == 2'h1 |-> {flash_configuration[24:23], flash_configuration[3:0]}
      == {boot_ecc_strap, boot_page_strap, boot_mode_pin_two,
      boot_mode_pin_one, boot_width_strap};
  endproperty
  a_strap: assert property (p_strap) else $error("strap load");
  c_lat: cover property ($fell(latch_strobe));
  c_phb: cover property ($fell(write_phase_b));
  c_wake: cover property ($rose(wake_from_sleep));
endmodule : nfcfg_regs_asserts
bind nfcfg_regs nfcfg_regs_asserts nfcfg_regs_asserts_inst (
  .clock, .nrst, .flash_configuration, .latch_strobe, .write_phase_a,
  .write_phase_b, .wake_from_sleep, .boot_mode_pin_two, .boot_mode_pin_one,
  .boot_ecc_strap, .boot_page_strap, .boot_width_strap, .internal_boot_rom,
  .wide_io, .addr_cycles_out, .page_bytes_out, .msg_bytes_out, .ecc_kind_out
);

// [nfcfg_flash_model.sv]
// flash-side model: measures how long each strobe of a cycle stands
// assumes registered strobe levels; clear wipes the last lengths
`timescale 1ns/1ps
module nfcfg_flash_model (
  input wire logic clock,
  input wire logic clear,
  input wire logic latch_strobe,
  input wire logic write_phase_a,
  input wire logic write_phase_b,
  output logic [3:0] latch_len,
  output logic [3:0] a_len,
  output logic [3:0] b_len
);
  logic [3:0] l_r, a_r, b_r;
  always_ff @(posedge clock) begin
    l_r <= latch_strobe ? l_r + 4'h1 : 4'h0;
    a_r <= write_phase_a ? a_r + 4'h1 : 4'h0;
    b_r <= write_phase_b ? b_r + 4'h1 : 4'h0;
    latch_len <= clear ? 4'h0 : (!latch_strobe && l_r != 0) ? l_r : latch_len;
    a_len <= clear ? 4'h0 : (!write_phase_a && a_r != 0) ? a_r : a_len;
    b_len <= clear ? 4'h0 : (!write_phase_b && b_r != 0) ? b_r : b_len;
  end
endmodule : nfcfg_flash_model

// [nfcfg_regs_tb.sv]
// testbench for the flash configuration register block
// assumes one wait state per avalon transfer, straps fixed at reset
`timescale 1ns/1ps
module nfcfg_regs_tb
  import nfcfg_pkg::*;
;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic rd = 1'b0, wr = 1'b0, cs = 1'b0, clr = 1'b0, rom = 1'b0, wake = 1'b0;
  logic p2 = 1'b0, p1 = 1'b1, pg = 1'b1, wd = 1'b1;
  logic [1:0] ecc = 2'h2;
  logic [7:0] adr = 8'h00;
  logic [3:0] be = 4'hF;
  logic [31:0] wdat = 32'h0, q, rdata, cfg, v;
  logic wreq, ls, wa, wb, busy, wio;
  logic [2:0] ac;
  logic [12:0] pb;
  logic [9:0] mb;
  logic [1:0] ek;
  logic [3:0] ll, al, bl;
  logic [8:0] tab [3] = '{9'h0D0, 9'h1C7, 9'h029};
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  nfcfg_regs nfcfg_regs_inst (
    .clock(clock), .nrst(nrst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_byteenable(be), .avs_writedata(wdat),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .boot_mode_pin_two(p2),
    .boot_mode_pin_one(p1), .boot_ecc_strap(ecc), .boot_page_strap(pg),
    .boot_width_strap(wd), .wake_from_sleep(wake), .internal_boot_rom(rom),
    .cycle_start(cs), .flash_configuration(cfg), .latch_strobe(ls),
    .write_phase_a(wa), .write_phase_b(wb), .cycle_busy(busy),
    .addr_cycles_out(ac), .page_bytes_out(pb), .msg_bytes_out(mb),
    .ecc_kind_out(ek), .wide_io(wio));
  nfcfg_flash_model nfcfg_flash_model_inst (
    .clock(clock), .clear(clr), .latch_strobe(ls), .write_phase_a(wa),
    .write_phase_b(wb), .latch_len(ll), .a_len(al), .b_len(bl));
  initial begin
    forever #12.5 clock = ~clock;
  end
  task automatic finish_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic [7:0] a, input logic w,
    input logic [31:0] d, input logic [3:0] b);
    @(posedge clock);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    be <= b;
    // this wait ends when waitrequest is seen low, or at the bench timeout
    do begin
      @(posedge clock);
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0, 4'hF);
    cmp(q, e);
  endtask : chk
  // packs ecc kind, address cycles, page bytes and message bytes
  function automatic logic [31:0] dec(input logic [31:0] c);
    logic [12:0] p;
    p = c[2] ? (c[3] ? NFCFG_PG_2K : NFCFG_PG_512)
      : (c[3] ? NFCFG_PG_4K : NFCFG_PG_2K);
    return {c[23], c[24], (c[2] && !c[3] ? 3'h3 : 3'h4) + 3'(c[1]), p,
      c[25] ? NFCFG_MSG_SHORT : NFCFG_MSG_LONG};
  endfunction : dec
  initial begin
    tick(4);
    nrst <= 1'b1;
    tick(3);
    cmp(cfg, 32'h0100100B);
    cmp({ek, ac, pb, mb}, dec(32'h0100100B));
    for (int i = 0; i < 16; i++) begin
      v = {6'h0, 3'(i >> 1), 19'h0, 4'(i)};
      bus(NFCFG_CONF_OFS, 1'b1, v, 4'hF);
      chk(NFCFG_CONF_OFS, v);
      tick(2);
      cmp({ek, ac, pb, mb}, dec(v));
    end
    bus(NFCFG_CONF_OFS, 1'b1, 32'hFFFFFFFF, 4'hF);
    chk(NFCFG_CONF_OFS, NFCFG_WMASK);
    bus(NFCFG_CONF_OFS, 1'b1, 32'h0, 4'hF);
    bus(NFCFG_CONF_OFS, 1'b1, 32'hFFFFFFFF, 4'h2);
    bus(8'h08, 1'b1, 32'hFFFFFFFF, 4'hF);
    chk(8'h08, 32'h0);
    chk(NFCFG_CONF_OFS, 32'h00007700);
    bus(NFCFG_CONF_OFS, 1'b1, 32'h1, 4'hF);
    tick(2);
    cmp(wio, 1'b1);
    rom <= 1'b1;
    tick(3);
    cmp(wio, 1'b0);
    rom <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      bus(NFCFG_CONF_OFS, 1'b1, {17'h0, tab[j][8:6], 1'b0, tab[j][5:3],
        1'b0, tab[j][2:0], 4'h0}, 4'hF);
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
      cs <= 1'b1;
      tick(1);
      cs <= 1'b0;
      tick(2);
      cmp(busy, 1'b1);
      for (int n = 0; busy !== 1'b0 && n < 40; n++) tick(1);
      cmp(busy, 1'b0);
      tick(3);
      cmp({ll, al, bl}, {4'(tab[j][8:6]), 4'(tab[j][5:3]) + 4'h1,
        4'(tab[j][2:0]) + 4'h1});
    end
    p2 <= 1'b1;
    p1 <= 1'b0;
    tick(1);
    wake <= 1'b1;
    tick(4);
    chk(NFCFG_CONF_OFS, 32'h00000514);
    chk(NFCFG_SLEEP_OFS, 32'h1);
    wake <= 1'b0;
    tick(2);
    finish_test();
  end
endmodule : nfcfg_regs_tb
